// ==== rtl/sleep_rail_pkg.sv ====
// Purpose: constants for the sleep rail pin control block
// Assumes: 32-bit classic Wishbone register access, 250 MHz clock
// Notes:   byte offsets are word aligned
package sleep_rail_pkg;
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] STATE_OFF  = 8'h04;
    localparam logic [7:0] STATUS_OFF = 8'h08;
    localparam logic [7:0] PIN_OFF    = 8'h0C;
    // control bit positions
    localparam int AG3_BIT     = 0;
    localparam int SX_BIT      = 1;
    localparam int DSX_DIS_BIT = 2;
    localparam int DC_DIS_BIT  = 3;
    localparam int HWLAN_BIT   = 4;
    localparam int DSWLAN_BIT  = 5;
    localparam int DSX_SUP_BIT = 6;
    localparam int NATIVE_BIT  = 7;
    localparam int DIR_BIT     = 8;
    localparam int GPO_BIT     = 9;
    localparam int ME_WLAN_BIT = 10;
    localparam int CTRL_W      = 11;
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h080;
    // status bits
    localparam int SMI_BIT     = 0;
    localparam int RTC_BIT     = 1;
    // shared pin hold time: initial low drive for straight-to-S5
    localparam int S5_HOLD_NS  = 1000;
    localparam int CLK_MHZ     = 250;
    localparam int S5_HOLD_CYC = (S5_HOLD_NS * CLK_MHZ) / 1000;

    typedef enum logic [2:0] {
        PS_S0     = 3'b000,
        PS_SX_M3  = 3'b001,
        PS_SX_OFF = 3'b011,
        PS_DEEP   = 3'b010,
        PS_G3     = 3'b110
    } pstate_t;

    typedef enum logic [1:0] {
        RS_IDLE  = 2'b00,
        RS_HOLD  = 2'b01,
        RS_STAY  = 2'b11
    } rstate_t;
endpackage

// ==== rtl/sleep_rail_if.sv ====
`timescale 1ns/1ps
// Purpose: carries policy inputs and rail results between top and rail decoder
// Assumes: one clock domain
// Notes:   combinational path
interface sleep_rail_if;
    logic                             s3_high;
    logic                             a_high;
    logic                             on_battery;
    logic                             after_g3;
    logic                             me_lan_req;
    logic                             me_wlan_req;
    logic                             me_wlan_access;
    logic [sleep_rail_pkg::CTRL_W-1:0] ctrl;
    sleep_rail_pkg::pstate_t          pstate;
    logic                             wired_en;
    logic                             wireless_en;
    modport top (output s3_high, a_high, on_battery, after_g3, me_lan_req, me_wlan_req,
                 me_wlan_access, ctrl, pstate, input wired_en, wireless_en);
    modport dec (input s3_high, a_high, on_battery, after_g3, me_lan_req, me_wlan_req,
                 me_wlan_access, ctrl, pstate, output wired_en, wireless_en);
endinterface

// ==== rtl/rail_policy.sv ====
`timescale 1ns/1ps
// Purpose: decides wired and wireless rail enable levels
// Assumes: all inputs synchronous
// Notes:   purely combinational, re-evaluated every cycle
module rail_policy (
    sleep_rail_if.dec p
);
    logic wired;
    logic wireless;
    always_comb begin
        wired    = 1'b0;
        wireless = 1'b0;
        if (p.s3_high || p.a_high) begin
            wired = 1'b1; // [R3]
        end
        if (p.me_lan_req && p.pstate != sleep_rail_pkg::PS_S0) begin
            wired = 1'b1; // [R4]
        end
        if (p.pstate == sleep_rail_pkg::PS_SX_M3 || p.pstate == sleep_rail_pkg::PS_SX_OFF) begin
            if (p.ctrl[sleep_rail_pkg::SX_BIT]) begin
                wired = 1'b1; // [R6]
            end
            if (p.after_g3 && p.ctrl[sleep_rail_pkg::AG3_BIT]) begin
                wired = 1'b1; // [R5]
            end
            if (p.ctrl[sleep_rail_pkg::HWLAN_BIT]) begin
                wireless = 1'b1; // [R10]
            end
            if (p.me_wlan_req) begin
                wireless = 1'b1;
            end
        end
        if (p.pstate == sleep_rail_pkg::PS_DEEP) begin
            if (!p.ctrl[sleep_rail_pkg::DSX_DIS_BIT] && (p.ctrl[sleep_rail_pkg::SX_BIT] || p.me_lan_req)) begin
                wired = 1'b1; // [R7]
            end
            if (p.ctrl[sleep_rail_pkg::DSWLAN_BIT]) begin
                wireless = 1'b1; // [R11]
            end
        end
        if (p.on_battery && p.ctrl[sleep_rail_pkg::DC_DIS_BIT] && !p.s3_high && !p.a_high && !p.me_lan_req) begin
            wired = 1'b0; // [R8]
        end
        if (p.s3_high) begin
            wireless = 1'b1; // [R9]
        end
        if (p.me_wlan_access && p.a_high) begin
            wireless = 1'b1; // [R12]
        end
    end
    assign p.wired_en    = wired;    // [R24]
    assign p.wireless_en = wireless;
endmodule

// ==== rtl/sleep_rail_pin_control.sv ====
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
// Purpose: suspend and rail control output pins with a Wishbone register file
// Assumes: synchronous inputs; rtc_well_reset_n low only in G3
// Notes:   rail levels are combinational from current state and policy
// Function
// R1: battery low with insufficient power blocks wake from S4, S5 and deep suspend; wake_allowed_o stays high in PS_SX_M3.
// R2: battery low asserting while in S0 raises a management interrupt.
// R3: wired rail enabled whenever S3 or management sleep output is high.
// R4: engine sets wired rail high when it needs the PHY in suspend.
// R5: after-G3 bit keeps wired rail enabled after a G3 transition.
// R6: suspend LAN bit keeps wired rail enabled in suspend and management-off.
// R7: deep-suspend disable bit cleared keeps wired rail in deep suspend.
// R8: battery disable bit drops wired rail while running from battery.
// R9: wireless rail enabled whenever S3 sleep output is high.
// R10: host wireless bit keeps wireless rail powered in S4 and S5.
// R11: deep-suspend wireless bit keeps wireless rail powered in deep suspend.
// R12: with engine access, wireless rail high whenever management sleep output high.
// R13: engine configures wireless rail high in suspend for wake on wireless.
// R14: acknowledge mode drives 0 in S0 and M3, engine policy in off.
// R15: warning mode drives 1 in S0 and suspend, asserts then floats entering deep; the code floats the pin at once in deep.
// R16: general-purpose mode: input floats, output drives data; off in deep suspend.
// R17: power-cycle and global reset force acknowledge 0; straight-to-S5 drives 0 first.
// R18: RTC reset returns RTC-well registers to defaults.
// R19: board asserts secure RTC reset only with RTC reset in G3.
// R20: neither RTC reset is pulled low from S0 through S5.
// R21: processor deep-idle gate driven low while processor is in C10.
// R22: deterministic-idle output driven low in S0i2.0 or S0i3.0.
// R23: no burst modes in legacy power management.
// R24: rail levels re-evaluated and updated in the same cycle as any change.
// R25: straight-to-S5 turns off sleep-controlled rails and holds host until wake.
module sleep_rail_pin_control (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // platform state
    input  wire logic [2:0]  power_state_i,
    input  wire logic        s3_sleep_out_n_i,
    input  wire logic        mgmt_sleep_out_n_i,
    input  wire logic        on_battery_i,
    input  wire logic        power_sufficient_i,
    input  wire logic        wake_event_i,
    input  wire logic        processor_c10_i,
    input  wire logic        deterministic_idle_i,
    // resets
    input  wire logic        power_cycle_reset_i,
    input  wire logic        global_reset_i,
    input  wire logic        straight_s5_reset_i,
    input  wire logic        rtc_well_reset_n_i,
    input  wire logic        secure_rtc_reset_n_i,
    // engine policy
    input  wire logic        me_lan_req_i,
    input  wire logic        me_wlan_req_i,
    input  wire logic        me_wlan_access_i,
    input  wire logic        me_ack_policy_i,
    // battery low
    input  wire logic        battery_low_n_i,
    // pins
    output logic             wired_lan_rail_en_o,
    output logic             wireless_rail_en_o,
    output logic             shared_pin_o,
    output logic             shared_pin_oe_o,
    input  wire logic        shared_pin_i,
    output logic             wake_allowed_o,
    output logic             host_hold_off_o,
    output logic             smi_o,
    output logic             processor_deep_idle_gate_n_o,
    output logic             deterministic_idle_out_n_o
);
    typedef struct packed {
        logic [sleep_rail_pkg::CTRL_W-1:0] ctrl;
        logic                              after_g3;
        logic                              smi;
        logic                              rtc_seen;
        logic                              battery_low_n_prev;
        logic                              ack;
        logic [31:0]                       rdata;
        sleep_rail_pkg::rstate_t           rst_st;
        logic [7:0]                        hold_cnt;
        logic                              gate_n;
        logic                              idle_n;
        logic                              pin_in;
    } state_t;

    state_t q;
    state_t d;

    sleep_rail_pkg::pstate_t pstate;
    logic                    wb_req;
    logic                    wb_wr;
    logic                    battery_low_n;
    logic                    s5_active;

    sleep_rail_if rif ();

    assign pstate    = sleep_rail_pkg::pstate_t'(power_state_i);
    assign wb_req    = wb_cyc_i && wb_stb_i && !q.ack;
    assign wb_wr     = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;
    assign battery_low_n    = !battery_low_n_i;
    assign s5_active = q.rst_st != sleep_rail_pkg::RS_IDLE;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign rif.s3_high        = s3_sleep_out_n_i && !s5_active;
    assign rif.a_high         = mgmt_sleep_out_n_i && !s5_active;
    assign rif.on_battery     = on_battery_i;
    assign rif.after_g3       = q.after_g3;
    assign rif.me_lan_req     = me_lan_req_i && !s5_active;
    assign rif.me_wlan_req    = me_wlan_req_i && !s5_active; // [R13]
    assign rif.me_wlan_access = me_wlan_access_i;
    assign rif.ctrl           = q.ctrl;
    assign rif.pstate         = pstate;

    rail_policy u_policy (
        .p (rif.dec)
    );

    always_comb begin
        logic [31:0] wv;
        wv = 32'h0000_0000;
        d  = q;
        d.ack = wb_req; // [R23] single transfers only, no burst
        d.pin_in = shared_pin_i;
        if (wb_wr && wb_adr_i == sleep_rail_pkg::CTRL_OFF) begin
            wv = merge({21'h00_0000, q.ctrl}, wb_dat_i, wb_sel_i);
            d.ctrl = wv[sleep_rail_pkg::CTRL_W-1:0];
        end
        if (pstate == sleep_rail_pkg::PS_G3) begin
            d.after_g3 = 1'b1;
        end else if (pstate == sleep_rail_pkg::PS_S0) begin
            d.after_g3 = 1'b0;
        end
        d.battery_low_n_prev = battery_low_n;
        // write-one-to-clear; a new event wins over the clear
        if (wb_wr && wb_adr_i == sleep_rail_pkg::STATUS_OFF && wb_sel_i[0]) begin
            if (wb_dat_i[sleep_rail_pkg::SMI_BIT]) begin
                d.smi = 1'b0;
            end
            if (wb_dat_i[sleep_rail_pkg::RTC_BIT]) begin
                d.rtc_seen = 1'b0;
            end
        end
        if (battery_low_n && !q.battery_low_n_prev && pstate == sleep_rail_pkg::PS_S0) begin
            d.smi = 1'b1; // [R2]
        end
        unique case (q.rst_st)
            sleep_rail_pkg::RS_IDLE: begin
                if (straight_s5_reset_i) begin
                    d.rst_st   = sleep_rail_pkg::RS_HOLD;
                    d.hold_cnt = 8'(sleep_rail_pkg::S5_HOLD_CYC);
                end
            end
            sleep_rail_pkg::RS_HOLD: begin
                if (q.hold_cnt == 8'h01) begin
                    d.rst_st = sleep_rail_pkg::RS_STAY;
                end
                d.hold_cnt = q.hold_cnt - 8'h01;
            end
            sleep_rail_pkg::RS_STAY: begin
                if (wake_event_i && !(battery_low_n && !power_sufficient_i)) begin
                    d.rst_st = sleep_rail_pkg::RS_IDLE; // [R25]
                end
            end
            default: begin
                d.rst_st = sleep_rail_pkg::RS_IDLE;
            end
        endcase
        d.gate_n = !processor_c10_i;      // [R21]
        d.idle_n = !deterministic_idle_i; // [R22]
        d.rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            sleep_rail_pkg::CTRL_OFF:   d.rdata = {21'h00_0000, q.ctrl};
            sleep_rail_pkg::STATE_OFF:  d.rdata = {26'h000_0000, wake_allowed_o, s5_active, q.after_g3, pstate};
            sleep_rail_pkg::STATUS_OFF: d.rdata = {30'h0000_0000, q.rtc_seen, q.smi};
            sleep_rail_pkg::PIN_OFF:    d.rdata = {28'h000_0000, q.pin_in, shared_pin_o, wireless_rail_en_o,
                                                   wired_lan_rail_en_o};
            default:                    d.rdata = 32'h0000_0000;
        endcase
        if (!rtc_well_reset_n_i) begin
            d.ctrl     = sleep_rail_pkg::CTRL_RST; // [R18]
            d.after_g3 = 1'b1;
            d.rtc_seen = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q.ctrl        <= sleep_rail_pkg::CTRL_RST;
            q.after_g3    <= 1'b1;
            q.smi         <= 1'b0;
            q.rtc_seen    <= 1'b0;
            q.battery_low_n_prev <= 1'b0;
            q.ack         <= 1'b0;
            q.rdata       <= 32'h0000_0000;
            q.rst_st      <= sleep_rail_pkg::RS_IDLE;
            q.hold_cnt    <= 8'h00;
            q.gate_n      <= 1'b1;
            q.idle_n      <= 1'b1;
            q.pin_in      <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // shared pin function select
    always_comb begin
        shared_pin_o    = 1'b0;
        shared_pin_oe_o = 1'b0;
        if (pstate == sleep_rail_pkg::PS_DEEP || pstate == sleep_rail_pkg::PS_G3) begin
            shared_pin_oe_o = 1'b0; // unpowered
        end else if (power_cycle_reset_i || global_reset_i || q.rst_st == sleep_rail_pkg::RS_HOLD) begin
            shared_pin_oe_o = 1'b1; // [R17]
        end else if (!q.ctrl[sleep_rail_pkg::NATIVE_BIT]) begin
            shared_pin_oe_o = !q.ctrl[sleep_rail_pkg::DIR_BIT]; // [R16]
            shared_pin_o    = q.ctrl[sleep_rail_pkg::GPO_BIT];
        end else if (q.ctrl[sleep_rail_pkg::DSX_SUP_BIT]) begin
            shared_pin_oe_o = 1'b1; // [R15]
            shared_pin_o    = !(straight_s5_reset_i);
        end else begin
            shared_pin_oe_o = 1'b1; // [R14]
            shared_pin_o    = (pstate == sleep_rail_pkg::PS_SX_OFF || q.rst_st == sleep_rail_pkg::RS_STAY)
                              ? me_ack_policy_i : 1'b0;
        end
    end

    assign wired_lan_rail_en_o          = rif.wired_en && !s5_active;    // [R25]
    assign wireless_rail_en_o           = rif.wireless_en && !s5_active; // [R25]
    assign wake_allowed_o               = !(battery_low_n && !power_sufficient_i &&
                                            pstate != sleep_rail_pkg::PS_S0 &&
                                            pstate != sleep_rail_pkg::PS_SX_M3); // [R1]
    assign host_hold_off_o              = s5_active;                             // [R25]
    assign smi_o                        = q.smi;
    assign processor_deep_idle_gate_n_o = q.gate_n;
    assign deterministic_idle_out_n_o   = q.idle_n;
    assign wb_ack_o                     = q.ack;
    assign wb_dat_o                     = q.rdata;
endmodule

// ==== verif/rail_board_model.sv ====
// Purpose: board side: shared pin wire, outside driver, RTC reset jumpers
// Assumes: clk_i is the block clock
// Notes:   an undriven wire shows the inverse of its last level
`timescale 1ns/1ps
module rail_board_model (
    input  wire logic       clk_i,
    input  wire logic       pin_o,
    input  wire logic       pin_oe_i,
    input  wire logic       ext_en_i,
    input  wire logic       ext_val_i,
    input  wire logic [2:0] ps_i,
    input  wire logic       rtc_req_i,
    output logic            pin_wire_o,
    output logic            rtc_n_o,
    output logic            srtc_n_o
);
    logic last_q;
    always_ff @(posedge clk_i) last_q <= pin_wire_o;
    assign pin_wire_o = pin_oe_i ? pin_o : (ext_en_i ? ext_val_i : ~last_q);
    // jumper is only closed in G3, never from S0 through S5
    assign rtc_n_o    = !(rtc_req_i && ps_i == sleep_rail_pkg::PS_G3);
    // secure reset only ever together with the main one
    assign srtc_n_o   = rtc_n_o;
endmodule

// ==== verif/sleep_rail_pin_control_properties.sv ====
// Purpose: port-level checks for the sleep rail pin control block
// Assumes: single clock, synchronous active high reset
// Notes:   bound to the top module below
`timescale 1ns/1ps
module sleep_rail_pin_control_properties (
    input wire logic       clk_i, rst_i, s3_sleep_out_n_i, mgmt_sleep_out_n_i, me_wlan_access_i,
    input wire logic [2:0] power_state_i,
    input wire logic       battery_low_n_i, power_sufficient_i, processor_c10_i, deterministic_idle_i,
    input wire logic       power_cycle_reset_i, global_reset_i, straight_s5_reset_i,
    input wire logic       wired_lan_rail_en_o, wireless_rail_en_o, shared_pin_o, shared_pin_oe_o,
    input wire logic       wake_allowed_o, host_hold_off_o, smi_o,
    input wire logic       processor_deep_idle_gate_n_o, deterministic_idle_out_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_s5_start;
        $rose(straight_s5_reset_i);
    endsequence
    sequence s_s5_held;
        (host_hold_off_o && !shared_pin_o) [*8];
    endsequence
    property p_wired_run;
        (s3_sleep_out_n_i || mgmt_sleep_out_n_i) && !host_hold_off_o |-> wired_lan_rail_en_o;
    endproperty
    property p_wless_host;
        s3_sleep_out_n_i && !host_hold_off_o |-> wireless_rail_en_o;
    endproperty
    property p_wless_mgmt;
        mgmt_sleep_out_n_i && me_wlan_access_i && !host_hold_off_o |-> wireless_rail_en_o;
    endproperty
    property p_c10_gate;
        1 |=> processor_deep_idle_gate_n_o == !$past(processor_c10_i);
    endproperty
    property p_idle_out;
        1 |=> deterministic_idle_out_n_o == !$past(deterministic_idle_i);
    endproperty
    property p_smi;
        $fell(battery_low_n_i) && power_state_i == sleep_rail_pkg::PS_S0 |-> ##[1:2] smi_o;
    endproperty
    property p_s5_seq;
        s_s5_start |=> s_s5_held;
    endproperty
    property p_s5_rails;
        host_hold_off_o |-> !wired_lan_rail_en_o && !wireless_rail_en_o;
    endproperty
    property p_reset_pin;
        (power_cycle_reset_i || global_reset_i) && shared_pin_oe_o |-> !shared_pin_o;
    endproperty
    property p_deep_off;
        power_state_i == sleep_rail_pkg::PS_DEEP && !host_hold_off_o |-> !shared_pin_oe_o;
    endproperty
    property p_battery_low_n;
        !battery_low_n_i && !power_sufficient_i
            && power_state_i inside {sleep_rail_pkg::PS_SX_OFF, sleep_rail_pkg::PS_DEEP} |-> !wake_allowed_o;
    endproperty
    a_wired_run: assert property (p_wired_run) else $error("wired rail low while running");
    a_wless_host: assert property (p_wless_host) else $error("wireless rail low with s3 high");
    a_wless_mgmt: assert property (p_wless_mgmt) else $error("wireless rail low with engine on");
    a_c10_gate: assert property (p_c10_gate) else $error("deep idle gate wrong");
    a_idle_out: assert property (p_idle_out) else $error("idle output wrong");
    a_smi: assert property (p_smi) else $error("no smi on battery low");
    a_s5_seq: assert property (p_s5_seq) else $error("straight s5 start wrong");
    a_s5_rails: assert property (p_s5_rails) else $error("rails on during hold off");
    a_reset_pin: assert property (p_reset_pin) else $error("pin high during reset");
    a_deep_off: assert property (p_deep_off) else $error("pin driven in deep suspend");
    a_battery_low_n: assert property (p_battery_low_n) else $error("wake allowed on battery low");
endmodule
bind sleep_rail_pin_control sleep_rail_pin_control_properties sleep_rail_pin_control_properties_i (
    .clk_i(clk_i), .rst_i(rst_i), .s3_sleep_out_n_i(s3_sleep_out_n_i), .mgmt_sleep_out_n_i(mgmt_sleep_out_n_i),
    .me_wlan_access_i(me_wlan_access_i), .power_state_i(power_state_i), .battery_low_n_i(battery_low_n_i),
    .power_sufficient_i(power_sufficient_i), .processor_c10_i(processor_c10_i),
    .deterministic_idle_i(deterministic_idle_i), .power_cycle_reset_i(power_cycle_reset_i),
    .global_reset_i(global_reset_i), .straight_s5_reset_i(straight_s5_reset_i),
    .wired_lan_rail_en_o(wired_lan_rail_en_o), .wireless_rail_en_o(wireless_rail_en_o),
    .shared_pin_o(shared_pin_o), .shared_pin_oe_o(shared_pin_oe_o), .wake_allowed_o(wake_allowed_o),
    .host_hold_off_o(host_hold_off_o), .smi_o(smi_o), .processor_deep_idle_gate_n_o(processor_deep_idle_gate_n_o),
    .deterministic_idle_out_n_o(deterministic_idle_out_n_o));

// ==== verif/test_sleep_rail_pin_control.sv ====
// Purpose: self-checking bench for the sleep rail pin control block
// Assumes: 250 MHz clock, Wishbone ack one cycle after the request edge
// Notes:   inputs change by non-blocking assignment on the rising edge or 1 ns after it
`timescale 1ns/1ps
module test_sleep_rail_pin_control;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, wired, wless, pin_o, pin_oe, pin_w;
    logic s3n = 1, mgn = 1, bat = 0, suff = 1, wake = 0, c10 = 0, didle = 0, pcr = 0, gr = 0, s5r = 0;
    logic lreq = 0, wreq = 0, wacc = 0, ackp = 0, batn = 1, ext_en = 1, ext_val = 1, rtc_req = 0;
    logic wake_ok, hold, smi, gate_n, idle_n, rtc_n, srtc_n;
    logic [2:0]  ps = 3'h0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, q;
    int errors = 0, compares = 0, n;
    always #2 clk_i = ~clk_i;
    sleep_rail_pin_control sleep_rail_pin_control_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .power_state_i(ps), .s3_sleep_out_n_i(s3n), .mgmt_sleep_out_n_i(mgn), .on_battery_i(bat),
        .power_sufficient_i(suff), .wake_event_i(wake), .processor_c10_i(c10), .deterministic_idle_i(didle),
        .power_cycle_reset_i(pcr), .global_reset_i(gr), .straight_s5_reset_i(s5r), .rtc_well_reset_n_i(rtc_n),
        .secure_rtc_reset_n_i(srtc_n), .me_lan_req_i(lreq), .me_wlan_req_i(wreq), .me_wlan_access_i(wacc),
        .me_ack_policy_i(ackp), .battery_low_n_i(batn), .wired_lan_rail_en_o(wired), .wireless_rail_en_o(wless),
        .shared_pin_o(pin_o), .shared_pin_oe_o(pin_oe), .shared_pin_i(pin_w), .wake_allowed_o(wake_ok),
        .host_hold_off_o(hold), .smi_o(smi), .processor_deep_idle_gate_n_o(gate_n),
        .deterministic_idle_out_n_o(idle_n));
    rail_board_model rail_board_model_i (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_i(pin_oe), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .ps_i(ps), .rtc_req_i(rtc_req), .pin_wire_o(pin_w), .rtc_n_o(rtc_n), .srtc_n_o(srtc_n));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
        do @(posedge clk_i);
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 0; stb <= 0;
    endtask
    // 1'bz as an expectation means the level is not judged
    task rails(input logic [2:0] p, input logic s3, a, b, ew, ewl);
        @(posedge clk_i);
        ps <= p; s3n <= s3; mgn <= a; bat <= b;
        #1;
        if (ew !== 1'bz) chk(wired, ew);
        if (ewl !== 1'bz) chk(wless, ewl);
    endtask
    task t_regs;
        wb(0, sleep_rail_pkg::CTRL_OFF, 0); chk(q, 32'h0000_0080);
        wb(1, 8'h10, 32'hFFFF_FFFF); wb(0, 8'h10, 0); chk(q, 32'h0000_0000);
        $display("test regs done");
    endtask
    task t_wired;
        wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_0082);
        rails(sleep_rail_pkg::PS_S0, 1, 1, 0, 1, 1);
        rails(sleep_rail_pkg::PS_SX_M3, 0, 1, 0, 1, 1'bz);
        rails(sleep_rail_pkg::PS_SX_OFF, 0, 0, 1, 1, 0);
        wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_008A);
        rails(sleep_rail_pkg::PS_SX_OFF, 0, 0, 1, 0, 0);
        lreq <= 1; rails(sleep_rail_pkg::PS_SX_OFF, 0, 0, 1, 1, 0);
        lreq <= 0; wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_0082);
        rails(sleep_rail_pkg::PS_DEEP, 0, 0, 0, 1, 0);
        wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_0086);
        rails(sleep_rail_pkg::PS_DEEP, 0, 0, 0, 0, 0);
        wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_0080);
        rails(sleep_rail_pkg::PS_SX_OFF, 0, 0, 0, 0, 0);
        $display("test wired done");
    endtask
    task t_wless;
        wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_0090);
        rails(sleep_rail_pkg::PS_SX_OFF, 0, 0, 0, 1'bz, 1);
        wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_00A0);
        rails(sleep_rail_pkg::PS_DEEP, 0, 0, 0, 1'bz, 1);
        wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_0080);
        rails(sleep_rail_pkg::PS_DEEP, 0, 0, 0, 1'bz, 0);
        wacc <= 1; rails(sleep_rail_pkg::PS_SX_M3, 0, 1, 0, 1, 1);
        wreq <= 1; rails(sleep_rail_pkg::PS_SX_OFF, 0, 0, 0, 1'bz, 1);
        wreq <= 0; wacc <= 0;
        $display("test wireless done");
    endtask
    task t_pin;
        rails(sleep_rail_pkg::PS_S0, 1, 1, 0, 1, 1);
        chk({pin_oe, pin_o}, 2'b10);
        ackp <= 1; rails(sleep_rail_pkg::PS_SX_OFF, 0, 0, 0, 1'bz, 1'bz); chk(pin_o, 1);
        ackp <= 0; rails(sleep_rail_pkg::PS_SX_OFF, 0, 0, 0, 1'bz, 1'bz); chk(pin_o, 0);
        wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_00C0); #1; chk(pin_o, 1);
        rails(sleep_rail_pkg::PS_DEEP, 0, 0, 0, 1'bz, 1'bz); chk(pin_oe, 0);
        wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_0100);
        rails(sleep_rail_pkg::PS_S0, 1, 1, 0, 1, 1); chk(pin_oe, 0);
        repeat (2) @(posedge clk_i);
        wb(0, sleep_rail_pkg::PIN_OFF, 0); chk(q[3], 1);
        wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_0200); #1; chk({pin_oe, pin_o}, 2'b11);
        wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_0000); #1; chk({pin_oe, pin_o}, 2'b10);
        wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_0080);
        $display("test pin done");
    endtask
    task t_resets;
        ackp <= 1; pcr <= 1; @(posedge clk_i); #1; chk(pin_o, 0);
        pcr <= 0; gr <= 1; @(posedge clk_i); #1; chk(pin_o, 0);
        gr <= 0; s5r <= 1; @(posedge clk_i); s5r <= 0;
        @(posedge clk_i); #1; chk({hold, wired, wless}, 3'b100);
        n = 1;
        while (pin_o === 1'b0 && n < 400) begin
            @(posedge clk_i); #1; n++;
        end
        chk(n >= sleep_rail_pkg::S5_HOLD_CYC && n <= sleep_rail_pkg::S5_HOLD_CYC + 2, 1);
        batn <= 0; suff <= 0; wake <= 1; rails(sleep_rail_pkg::PS_SX_OFF, 0, 0, 0, 0, 0);
        repeat (4) @(posedge clk_i); #1; chk({hold, wake_ok}, 2'b10);
        batn <= 1; suff <= 1; repeat (4) @(posedge clk_i); #1; chk(hold, 0);
        wake <= 0; ackp <= 0;
        $display("test resets done");
    endtask
    task t_smi_idle;
        rails(sleep_rail_pkg::PS_S0, 1, 1, 0, 1, 1);
        batn <= 0; c10 <= 1; didle <= 1; repeat (3) @(posedge clk_i); #1;
        chk({smi, gate_n, idle_n}, 3'b100);
        wb(0, sleep_rail_pkg::STATUS_OFF, 0); chk(q[0], 1);
        batn <= 1; c10 <= 0; didle <= 0;
        wb(1, sleep_rail_pkg::STATUS_OFF, 32'h0000_0001); #1; chk({smi, gate_n, idle_n}, 3'b011);
        $display("test smi and idle done");
    endtask
    task t_rtc;
        wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_008F);
        rails(sleep_rail_pkg::PS_G3, 0, 0, 0, 1'bz, 1'bz);
        rtc_req <= 1; repeat (2) @(posedge clk_i); rtc_req <= 0;
        wb(0, sleep_rail_pkg::CTRL_OFF, 0); chk(q, 32'h0000_0080);
        wb(0, sleep_rail_pkg::STATUS_OFF, 0); chk(q[1], 1);
        wb(1, sleep_rail_pkg::CTRL_OFF, 32'h0000_0081);
        rails(sleep_rail_pkg::PS_SX_OFF, 0, 0, 0, 1, 0);
        $display("test rtc done");
    endtask
    task wrap_up;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        t_regs; t_wired; t_wless; t_pin; t_resets; t_smi_idle; t_rtc;
        wrap_up;
    end
    initial begin
        #40000;
        errors++;
        wrap_up;
    end
endmodule
